// ### pkg/io_map_pkg.sv
// Constants for the terminal polarity and output select block
package io_map_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_POLARITY = 8'h00;
  localparam logic [7:0] OFF_SEL_BASE = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_INFUNC_BASE = 8'h24;
  localparam logic [7:0] OFF_TERM = 8'h44;
  localparam logic [7:0] OFF_ANGLE = 8'h48;
  // Counts and widths
  localparam int N_IN = 8;
  localparam int N_OUT = 6;
  localparam int N_FUNC = 64;
  // Reset values
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [6:0] SEL_RST_0 = 7'h46;
  localparam logic [6:0] SEL_RST_1 = 7'h45;
  localparam logic [6:0] SEL_RST_2 = 7'h49;
  localparam logic [6:0] SEL_RST_3 = 7'h43;
  localparam logic [6:0] SEL_RST_4 = 7'h42;
  localparam logic [6:0] SEL_RST_5 = 7'h41;
  // Input function reset map: 3,4,48,49,50,16,18,24
  localparam logic [5:0] FUNC_RST_0 = 6'h03;
  localparam logic [5:0] FUNC_RST_1 = 6'h04;
  localparam logic [5:0] FUNC_RST_2 = 6'h30;
  localparam logic [5:0] FUNC_RST_3 = 6'h31;
  localparam logic [5:0] FUNC_RST_4 = 6'h32;
  localparam logic [5:0] FUNC_RST_5 = 6'h10;
  localparam logic [5:0] FUNC_RST_6 = 6'h12;
  localparam logic [5:0] FUNC_RST_7 = 6'h18;
  // Selection numbers
  localparam logic [6:0] SEL_NONE = 7'h00;
  localparam logic [6:0] SEL_FLAG_LO = 7'h20;
  localparam logic [6:0] SEL_FLAG_HI = 7'h2F;
  localparam logic [6:0] SEL_LS_POS = 7'h3C;
  localparam logic [6:0] SEL_LS_NEG = 7'h3D;
  localparam logic [6:0] SEL_HOMES = 7'h3E;
  localparam logic [6:0] SEL_SLIT = 7'h3F;
  localparam logic [6:0] SEL_FAULT = 7'h41;
  localparam logic [6:0] SEL_CAUTION = 7'h42;
  localparam logic [6:0] SEL_READY = 7'h43;
  localparam logic [6:0] SEL_MOVE = 7'h44;
  localparam logic [6:0] SEL_END = 7'h45;
  localparam logic [6:0] SEL_ORIGIN = 7'h46;
  localparam logic [6:0] SEL_TORQUE = 7'h47;
  localparam logic [6:0] SEL_ANGLE = 7'h48;
  localparam logic [6:0] SEL_WIN1 = 7'h49;
  localparam logic [6:0] SEL_WIN2 = 7'h4A;
  localparam logic [6:0] SEL_WIN3 = 7'h4B;
  localparam logic [6:0] SEL_BUSY = 7'h50;
  localparam logic [6:0] SEL_SUPPLY = 7'h52;
  // Shaft angle: one pulse per 7.2 degrees, in tenths of a degree
  localparam int ANGLE_STEP_TENTHS = 72;
  localparam logic [15:0] ANGLE_PULSE_RST = 16'h0001;
  // Main supply selection exists only on the AC variant
  localparam bit AC_VARIANT = 1'b1;
  // Echo-able input function numbers (1..13, 16..18, 48..53)
  function automatic logic echo_ok(input logic [5:0] f);
    return (f >= 6'h01 && f <= 6'h0D) || (f >= 6'h10 && f <= 6'h12) ||
           (f >= 6'h30 && f <= 6'h35);
  endfunction : echo_ok
endpackage : io_map_pkg

// ### hdl/sel_mem.sv
// Small register memory holding the six output selection numbers
`timescale 1ns/10ps
module sel_mem
  import io_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [6:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [6:0] rdata_o,
  output logic [6*7-1:0] all_o
);
  logic [6:0] mem_r [N_OUT];

  // Storage with reset defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_r[0] <= SEL_RST_0;
      mem_r[1] <= SEL_RST_1;
      mem_r[2] <= SEL_RST_2;
      mem_r[3] <= SEL_RST_3;
      mem_r[4] <= SEL_RST_4;
      mem_r[5] <= SEL_RST_5;
    end else if (we_i && waddr_i < 3'd6) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 7'h00;
    end else begin
      rdata_o <= (raddr_i < 3'd6) ? mem_r[raddr_i] : 7'h00;
    end
  end

  // Flat view for the selectors
  always_comb begin
    for (int k = 0; k < N_OUT; k++) begin
      all_o[k*7 +: 7] = mem_r[k];
    end
  end
endmodule : sel_mem

// ### hdl/io_polarity_select.sv
// Input polarity, input function map and output selection with Wishbone
// Notes on behaviour
// R1 - Per-terminal polarity: 0 open, 1 closed
// R2 - All polarities reset to normally open
// R3 - Six outputs, each from own selection
// R4 - Selection 0 drives output inactive
// R5 - Selections 1 to 7 echo run inputs
// R6 - Selections 8 to 13 echo direct selects
// R7 - Selections 16 to 18 echo free/on/stop
// R8 - Selections 32 to 47 output flags
// R9 - Selections 48 to 53 echo data bits
// R10 - Selections 60 to 63 echo sensors
// R11 - Selection 65 active while no alarm
// R12 - Selection 66 active on warning
// R13 - Selection 67 active when ready
// R14 - Selection 68 active while moving
// R15 - Selection 69 active at positioning end
// R16 - Selection 70 active at origin
// R17 - Selection 71 active on torque limit
// R18 - Selection 72 pulses every 7.2 degrees
// R19 - Selections 73 to 75 follow windows
// R20 - Selection 80 active while busy
// R21 - Selection 82 main supply, AC only
// R22 - Function on several terminals ORs them
// R23 - Unlisted selections behave like 0
// R24 - Polarity applied before any use
`timescale 1ns/10ps
module io_polarity_select
  import io_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [N_IN-1:0] input_terminal_i,
  input wire logic [3:0] sensor_i,
  input wire logic alarm_i,
  input wire logic warning_i,
  input wire logic ready_i,
  input wire logic moving_i,
  input wire logic end_i,
  input wire logic origin_i,
  input wire logic torque_limit_i,
  input wire logic shaft_step_i,
  input wire logic [2:0] window_i,
  input wire logic busy_i,
  input wire logic main_supply_i,
  output logic [N_OUT-1:0] output_terminal_o,
  output logic [N_FUNC-1:0] func_active_o
);
  // Pin synchronisers
  logic [N_IN-1:0] term_s1_r, term_s2_r;
  logic [3:0] sens_s1_r, sens_s2_r;
  logic [11:0] stat_s1_r, stat_s2_r;
  logic step_s3_r;
  // Configuration
  logic [7:0] polarity_r;
  logic [15:0] flags_r;
  logic [5:0] infunc_r [N_IN];
  logic [15:0] angle_count_r;
  logic ack_r, err_r;
  logic [31:0] dat_r;
  logic [N_OUT-1:0] out_r;
  logic [N_FUNC-1:0] func_r;
  // Decoded bus
  wire req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  wire [7:0] a = wb_adr_i[7:0];
  wire hit_pol = (a == OFF_POLARITY);
  wire hit_sel = (a >= OFF_SEL_BASE) && (a < OFF_FLAGS);
  wire hit_flg = (a == OFF_FLAGS);
  wire hit_sta = (a == OFF_STATUS);
  wire hit_fn = (a >= OFF_INFUNC_BASE) && (a < OFF_TERM);
  wire hit_trm = (a == OFF_TERM);
  wire hit_ang = (a == OFF_ANGLE);
  wire mapped = (wb_adr_i[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
                (hit_pol || hit_sel || hit_flg || hit_sta || hit_fn ||
                 hit_trm || hit_ang);
  wire wr = req && mapped && wb_we_i;
  wire [7:0] sel_off = a - OFF_SEL_BASE;
  wire [7:0] fn_off = a - OFF_INFUNC_BASE;
  wire [2:0] sel_idx = sel_off[4:2];
  wire [2:0] fn_idx = fn_off[4:2];
  wire [6:0] sel_rd;
  wire [6*7-1:0] sel_all;
  // Polarity corrected terminals
  wire [N_IN-1:0] term_act = term_s2_r ^ polarity_r; // R1 R24

  sel_mem u_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr && hit_sel && wb_sel_i[0]),
    .waddr_i(sel_idx),
    .wdata_i(wb_dat_i[6:0]),
    .raddr_i(sel_idx),
    .rdata_o(sel_rd),
    .all_o(sel_all)
  );

  // Two-stage synchronisers on every pin
  always_ff @(posedge clk_i) begin
    term_s1_r <= input_terminal_i;
    term_s2_r <= term_s1_r;
    sens_s1_r <= sensor_i;
    sens_s2_r <= sens_s1_r;
    stat_s1_r <= {main_supply_i, busy_i, window_i, shaft_step_i,
                  torque_limit_i, origin_i, end_i, moving_i, ready_i,
                  warning_i ^ alarm_i ^ alarm_i};
    stat_s2_r <= stat_s1_r;
    step_s3_r <= stat_s2_r[6];
  end

  // Alarm captured separately to keep its own bit
  logic alarm_s1_r, alarm_s2_r;
  always_ff @(posedge clk_i) begin
    alarm_s1_r <= alarm_i;
    alarm_s2_r <= alarm_s1_r;
  end

  // Function activity: OR over all terminals mapped to each echo-able function; 60 to 63 follow the sensors
  logic [N_FUNC-1:0] func_nxt;
  always_comb begin
    func_nxt = '0;
    for (int t = 0; t < N_IN; t++) begin
      if (echo_ok(infunc_r[t]) && term_act[t]) begin
        func_nxt[infunc_r[t]] = 1'b1; // R22 R24
      end
    end
    func_nxt[SEL_LS_POS[5:0]] = sens_s2_r[0]; // R10
    func_nxt[SEL_LS_NEG[5:0]] = sens_s2_r[1]; // R10
    func_nxt[SEL_HOMES[5:0]] = sens_s2_r[2]; // R10
    func_nxt[SEL_SLIT[5:0]] = sens_s2_r[3]; // R10
  end

  // Shaft angle pulse on each 7.2 degree step edge
  wire step_edge = stat_s2_r[6] && !step_s3_r;
  wire angle_pulse = step_edge; // R18

  // Output selection per terminal
  function automatic logic pick(input logic [6:0] s,
                                input logic [N_FUNC-1:0] fa,
                                input logic [15:0] fl,
                                input logic [11:0] st,
                                input logic fault_output,
                                input logic ap);
    logic v;
    v = 1'b0; // R4 R23
    if ((s >= 7'h01 && s <= 7'h0D) || (s >= 7'h10 && s <= 7'h12) ||
        (s >= 7'h30 && s <= 7'h35) || (s >= SEL_LS_POS && s <= SEL_SLIT)) begin
      v = fa[s[5:0]]; // R5 R6 R7 R9 R10
    end else if (s >= SEL_FLAG_LO && s <= SEL_FLAG_HI) begin
      v = fl[s[3:0]]; // R8
    end else begin
      case (s)
        SEL_FAULT: v = !fault_output; // R11
        SEL_CAUTION: v = st[0]; // R12
        SEL_READY: v = st[1]; // R13
        SEL_MOVE: v = st[2]; // R14
        SEL_END: v = st[3]; // R15
        SEL_ORIGIN: v = st[4]; // R16
        SEL_TORQUE: v = st[5]; // R17
        SEL_ANGLE: v = ap; // R18
        SEL_WIN1: v = st[7]; // R19
        SEL_WIN2: v = st[8]; // R19
        SEL_WIN3: v = st[9]; // R19
        SEL_BUSY: v = st[10]; // R20
        SEL_SUPPLY: v = AC_VARIANT && st[11]; // R21
        default: v = 1'b0; // R23
      endcase
    end
    return v;
  endfunction : pick

  logic [N_OUT-1:0] out_nxt;
  always_comb begin
    for (int k = 0; k < N_OUT; k++) begin
      out_nxt[k] = pick(sel_all[k*7 +: 7], func_nxt, flags_r, stat_s2_r,
                        alarm_s2_r, angle_pulse); // R3
    end
  end

  // Read data mux
  wire [31:0] rd_nxt =
    hit_pol ? {24'h000000, polarity_r} :
    hit_flg ? {16'h0000, flags_r} :
    hit_sta ? {19'h00000, alarm_s2_r, stat_s2_r} :
    hit_fn ? {26'h0000000, infunc_r[fn_idx]} :
    hit_trm ? {18'h00000, out_r, term_act} :
    hit_ang ? {16'h0000, angle_count_r} : 32'h00000000;

  // Configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      polarity_r <= POLARITY_RST; // R2
      flags_r <= 16'h0000;
      infunc_r <= '{FUNC_RST_0, FUNC_RST_1, FUNC_RST_2, FUNC_RST_3,
                    FUNC_RST_4, FUNC_RST_5, FUNC_RST_6, FUNC_RST_7};
    end else if (wr) begin
      if (hit_pol && wb_sel_i[0]) polarity_r <= wb_dat_i[7:0]; // R1
      if (hit_flg && wb_sel_i[0]) flags_r[7:0] <= wb_dat_i[7:0];
      if (hit_flg && wb_sel_i[1]) flags_r[15:8] <= wb_dat_i[15:8];
      if (hit_fn && wb_sel_i[0]) infunc_r[fn_idx] <= wb_dat_i[5:0];
    end
  end

  // Bus answer one cycle after request; outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h00000000;
      out_r <= '0;
      func_r <= '0;
      angle_count_r <= 16'h0000;
    end else begin
      ack_r <= req && mapped;
      err_r <= req && !mapped;
      dat_r <= rd_nxt;
      out_r <= out_nxt; // R3
      func_r <= func_nxt;
      if (angle_pulse) angle_count_r <= angle_count_r + ANGLE_PULSE_RST;
    end
  end

  // Selection reads come out of the memory register
  assign wb_dat_o = hit_sel ? {25'h0000000, sel_rd} : dat_r;
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign output_terminal_o = out_r;
  assign func_active_o = func_r;

  // Checks
  chk_zero_inactive: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_all[6:0] == SEL_NONE) |=> !output_terminal_o[0]) // R4
    else $error("output 0 active with no function");
  chk_fault_inv: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_all[6:0] == SEL_FAULT && $stable(sel_all[6:0])) |=>
    (output_terminal_o[0] == !$past(alarm_s2_r))) // R11
    else $error("fault output not inverted alarm");
  chk_pol_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> polarity_r == 8'h00) // R2
    else $error("polarity not cleared by reset");
  chk_flag_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_all[13:7] == 7'h25) |=> output_terminal_o[1] == $past(flags_r[5])) // R8
    else $error("flag 5 not on output 1");
  chk_unlisted: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_all[20:14] == 7'h40) |=> !output_terminal_o[2]) // R23
    else $error("unlisted selection drives output");
  chk_busy_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_all[27:21] == SEL_BUSY) |=> output_terminal_o[3] == $past(stat_s2_r[10])) // R20
    else $error("busy not on output 3");
  chk_ready_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_all[34:28] == SEL_READY) |=> output_terminal_o[4] == $past(stat_s2_r[1])) // R13
    else $error("ready not on output 4");
  chk_term_or: assert property (@(posedge clk_i) disable iff (rst_i)
    (infunc_r[0] == 6'h01 && term_act[0]) |=> func_active_o[1]) // R22
    else $error("terminal 0 function not active");
endmodule : io_polarity_select

// ### verification/host_model.sv
// Host controller contacts wired to the input terminals
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] closed_i,
  output logic [7:0] terminal_o
);
  // Contacts settle one clock after the host moves them
  always_ff @(posedge clk_i) begin
    terminal_o <= closed_i;
  end
endmodule : host_model

// ### verification/driver_io_polarity_and_output_select_test.sv
// Self-checking bench for terminal polarity and output select
`timescale 1ns/10ps
module driver_io_polarity_and_output_select_test;
  import io_map_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, err, e;
  logic [31:0] adr, wdat, rdat, q, r;
  logic [7:0] closed, term, pol;
  logic [15:0] flg;
  logic [3:0] sens;
  logic [2:0] win;
  logic fault_output, caution_output, rdy, mov, fin, org, torque_limit_output, stp, bsy, sup;
  logic [N_OUT-1:0] outs;
  logic [6:0] sel [6];
  logic [5:0] fn [8];
  int errors, num_checks, cycles, n;
  int seed = 55;

  // Host side and device
  host_model host (.clk_i(clk_i), .closed_i(closed), .terminal_o(term));
  io_polarity_select dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .input_terminal_i(term), .sensor_i(sens),
    .alarm_i(fault_output), .warning_i(caution_output), .ready_i(rdy), .moving_i(mov),
    .end_i(fin), .origin_i(org), .torque_limit_i(torque_limit_output),
    .shaft_step_i(stp), .window_i(win), .busy_i(bsy),
    .main_supply_i(sup), .output_terminal_o(outs),
    .func_active_o());

  // Clock generator
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk

  // Classic single Wishbone cycle, result left in q and e
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= {24'h0, a};
    we <= w;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    q = rdat;
    e = err;
    if (k >= 20) errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Expected level of an output for a selection number
  function automatic logic exp_out(input logic [6:0] s);
    logic [7:0] c;
    logic fa;
    c = closed ^ pol;
    fa = 1'b0;
    for (int i = 0; i < 8; i++) if (fn[i] == s[5:0] && c[i]) fa = 1'b1;
    if ((s >= 7'h01 && s <= 7'h0D) || (s >= 7'h10 && s <= 7'h12) ||
        (s >= 7'h30 && s <= 7'h35)) return fa;
    if (s >= SEL_FLAG_LO && s <= SEL_FLAG_HI) return flg[s - 7'h20];
    if (s >= SEL_LS_POS && s <= SEL_SLIT) return sens[s - 7'h3C];
    case (s)
      SEL_FAULT: return !fault_output;
      SEL_CAUTION: return caution_output;
      SEL_READY: return rdy;
      SEL_MOVE: return mov;
      SEL_END: return fin;
      SEL_ORIGIN: return org;
      SEL_TORQUE: return torque_limit_output;
      SEL_WIN1: return win[0];
      SEL_WIN2: return win[1];
      SEL_WIN3: return win[2];
      SEL_BUSY: return bsy;
      SEL_SUPPLY: return sup & AC_VARIANT;
      default: return 1'b0;
    endcase
  endfunction : exp_out

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  // Main sequence
  initial begin
    {rst_i, cyc, stb, we, adr, wdat, closed, sens, win} = '0;
    {fault_output, caution_output, rdy, mov, fin, org, torque_limit_output, stp, bsy, sup} = '0;
    rst_i = 1'b1;
    sel = '{SEL_RST_0, SEL_RST_1, SEL_RST_2, SEL_RST_3, SEL_RST_4,
      SEL_RST_5};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(OFF_POLARITY, 1'b0, 32'h0);
    chk(32'h0, q);
    for (int k = 0; k < 6; k++) begin
      wb(OFF_SEL_BASE + 8'(4 * k), 1'b0, 32'h0);
      chk({25'h0, sel[k]}, q);
    end
    wb(8'h80, 1'b0, 32'h0);
    chk(32'h1, {31'h0, e});
    // Every selection number with random terminals and status
    for (int s = 0; s < 128; s++) begin
      r = $random(seed);
      pol = r[7:0];
      flg = r[23:8];
      wb(OFF_POLARITY, 1'b1, {24'h0, pol});
      wb(OFF_FLAGS, 1'b1, {16'h0, flg});
      for (int i = 0; i < 8; i++) begin
        r = $random(seed);
        fn[i] = r[0] ? 6'(s) : r[6:1];
        wb(OFF_INFUNC_BASE + 8'(4 * i), 1'b1, {26'h0, fn[i]});
      end
      sel[s % 6] = 7'(s);
      wb(OFF_SEL_BASE + 8'(4 * (s % 6)), 1'b1, 32'(s));
      r = $random(seed);
      @(posedge clk_i);
      closed <= r[7:0];
      {sup, bsy, win, torque_limit_output, org, fin, mov, rdy, caution_output, fault_output} <= r[19:8];
      sens <= r[23:20];
      repeat (5) @(posedge clk_i);
      wb(OFF_TERM, 1'b0, 32'h0);
      chk({24'h0, closed ^ pol}, {24'h0, q[7:0]});
      for (int k = 0; k < 6; k++) begin
        chk({31'h0, exp_out(sel[k])}, {31'h0, outs[k]});
      end
    end
    // One pulse per shaft step edge, none while the level holds
    wb(OFF_SEL_BASE, 1'b1, {25'h0, SEL_ANGLE});
    repeat (5) @(posedge clk_i);
    stp <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (outs[0] === 1'b1) n++;
    end
    chk(32'h1, 32'(n));
    results();
  end
endmodule : driver_io_polarity_and_output_select_test
